/* File: design/mpcm_power_clock.sv */
// Summary of operation
// - clock control bit 7 enables PLL
// - PLL on: three-bit frequency select
// - PLL off: two-bit frequency select
// - power-down bit 3 reads low-frequency clock
// - power-down write with nonzero bits 2:0 enters standby
// - all reset sources share one sequence
// - reset cause bit 0 flags watchdog
// - RF wake field selects condition
// - pin/timer wake field selects condition
// - USB interrupt wake field selects condition
// - USB bus wake field selects condition
// - power control bit 7 baud doubler
// - four general flags, storage only
// - power control bit 4 program write
// - stop bit pulses, reads zero
// - idle bit pulses, reads zero
// - PLL triples oscillator for USB
// - software PLL control only in suspend
// - qualified wake source ends standby
`timescale 1ns/1ps
module mpcm_power_clock
    import mpcm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wdt_reset_req,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        usb_suspended,
    input  wire logic        rf_interrupt,
    input  wire logic        pin_timer_wake_event,
    input  wire logic        usb_interrupt,
    input  wire logic        usb_bus_wake,
    output logic             pll_enable,
    output logic             mcu_clk_en,
    output logic             mcu_standby,
    output logic             low_freq_clock,
    output logic             baud_doubler,
    output logic             prog_write_enable,
    output logic             stop_request,
    output logic             idle_request
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0]      power_control;
        logic [7:0]      clock_control;
        logic [7:0]      wakeup_configuration;
        logic [7:0]      interrupt_enable_high;
        logic            reset_cause;
        mpcm_mcu_state_t mcu_state;
        logic            pll_on;
        logic [MPCM_DIV_W-1:0] div_cnt;
        logic [MPCM_DIV_W-1:0] div_limit;
        logic [MPCM_DIV_W-1:0] lf_cnt;
        logic            lf_level;
        logic            clk_en;
        logic            stop_p;
        logic            idle_p;
        logic [31:0]     rdata;
        logic            ack;
    } mpcm_state_t;

    mpcm_state_t state;
    mpcm_state_t next_state;

    // divide count for the selected mcu rate from the system clock
    function automatic logic [MPCM_DIV_W-1:0] mcu_divide
    (
        input logic       pll,
        input logic [7:0] cc
    );
        logic [MPCM_DIV_W-1:0] d;
        d = 16'h0000;
        if (pll)
        begin
            case (cc[MPCM_CC_ON_HI:MPCM_CC_ON_LO])
                3'h0: d = 16'(MPCM_SYS_CLK_KHZ / 16000);
                3'h1: d = 16'(MPCM_SYS_CLK_KHZ / 12000);
                3'h2: d = 16'(MPCM_SYS_CLK_KHZ / 8000);
                3'h3: d = 16'(MPCM_SYS_CLK_KHZ / 4000);
                default: d = 16'(MPCM_SYS_CLK_KHZ / 1600);
            endcase
        end
        else
        begin
            case (cc[MPCM_CC_OFF_HI:MPCM_CC_OFF_LO])
                2'h0: d = 16'(MPCM_SYS_CLK_KHZ / 4000);
                2'h1: d = 16'(MPCM_SYS_CLK_KHZ / 1600);
                2'h2: d = 16'(MPCM_SYS_CLK_KHZ / 320);
                default: d = 16'(MPCM_SYS_CLK_KHZ / 64);
            endcase
        end
        return d;
    endfunction

    // one wake source qualified by its two-bit field and enable
    function automatic logic wake_qualify
    (
        input logic [1:0] code,
        input logic       src,
        input logic       en
    );
        logic w;
        w = 1'b0;
        case (code)
            MPCM_WAKE_IF_ENABLED: w = src & en;
            MPCM_WAKE_ALWAYS:     w = src;
            default:              w = 1'b0;
        endcase
        return w;
    endfunction

    logic       bus_req;
    logic       wr_en;
    logic [7:0] wbyte;
    logic       wake;
    logic [1:0] wf;
    logic [2:0] on_code;
    logic [3:0] wake_src;

    // ack masks the strobe so one request is taken only once
    assign bus_req = wb_cyc_i & wb_stb_i & ~state.ack;
    assign wr_en   = bus_req & wb_we_i & wb_sel_i[0];
    assign wbyte   = wb_dat_i[7:0];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_state        = state;
        next_state.stop_p = 1'b0;
        next_state.idle_p = 1'b0;
        next_state.ack    = bus_req;
        on_code           = wbyte[MPCM_CC_ON_HI:MPCM_CC_ON_LO];
        wf                = 2'h0;

        wake_src[3] = wake_qualify(
                   state.wakeup_configuration[MPCM_WC_RF_LO +: 2],
                   rf_interrupt,
                   state.interrupt_enable_high[MPCM_IE_RF_BIT]);
        wake_src[2] = wake_qualify(
                   state.wakeup_configuration[MPCM_WC_PIN_LO +: 2],
                   pin_timer_wake_event,
                   state.interrupt_enable_high[MPCM_IE_PIN_BIT]);
        wake_src[1] = wake_qualify(
                   state.wakeup_configuration[MPCM_WC_USB_LO +: 2],
                   usb_interrupt,
                   state.interrupt_enable_high[MPCM_IE_USB_BIT]);
        wake_src[0] = wake_qualify(
                   state.wakeup_configuration[MPCM_WC_USB_BUS_LO +: 2],
                   usb_bus_wake,
                   state.interrupt_enable_high[MPCM_IE_USB_BUS_BIT]);
        wake = |wake_src;

        if (wr_en)
        begin
            if (wb_adr_i == MPCM_ADDR_POWER_CONTROL)
            begin
                next_state.power_control = wbyte & MPCM_PC_RW_MASK;
                next_state.stop_p = wbyte[MPCM_PC_STOP_BIT];
                next_state.idle_p = wbyte[MPCM_PC_IDLE_BIT];
            end
            else if (wb_adr_i == MPCM_ADDR_CLOCK_CONTROL)
            begin
                next_state.clock_control[MPCM_CC_PLL_BIT] =
                    wbyte[MPCM_CC_PLL_BIT];
                next_state.clock_control[MPCM_CC_OFF_HI:MPCM_CC_OFF_LO] =
                    wbyte[MPCM_CC_OFF_HI:MPCM_CC_OFF_LO];
                if (on_code <= MPCM_ON_MAX_CODE)
                begin
                    next_state.clock_control[MPCM_CC_ON_HI:MPCM_CC_ON_LO] =
                        on_code;
                end
            end
            else if (wb_adr_i == MPCM_ADDR_POWER_DOWN)
            begin
                if (wbyte[MPCM_PD_CMD_HI:0] != 3'h0)
                begin
                    next_state.mcu_state = MPCM_ST_STANDBY;
                end
            end
            else if (wb_adr_i == MPCM_ADDR_WAKEUP_CONFIG)
            begin
                for (int i = 0; i < 4; i++)
                begin
                    wf = wbyte[2*i +: 2];
                    if (wf != MPCM_WAKE_RESERVED)
                    begin
                        next_state.wakeup_configuration[2*i +: 2] = wf;
                    end
                end
            end
            else if (wb_adr_i == MPCM_ADDR_INT_ENABLE_HI)
            begin
                next_state.interrupt_enable_high = wbyte;
            end
        end

        // wake ends standby; a wake in the command cycle from active is lost
        case (state.mcu_state)
            MPCM_ST_STANDBY:
            begin
                if (wake)
                begin
                    next_state.mcu_state = MPCM_ST_ACTIVE;
                end
            end
            default:
            begin
            end
        endcase

        // hardware forces PLL on unless usb suspended
        next_state.pll_on = usb_suspended ?
                            state.clock_control[MPCM_CC_PLL_BIT] : 1'b1;

        // a new rate waits out the running period, so a switch can
        // lag by up to one slowest period; no short pulse gets out
        // new divide taken only at a period boundary
        next_state.clk_en = 1'b0;
        if (state.div_cnt >= state.div_limit - 16'h0001)
        begin
            next_state.div_cnt   = 16'h0000;
            next_state.div_limit = mcu_divide(state.pll_on,
                                              state.clock_control);
            next_state.clk_en    = (state.mcu_state == MPCM_ST_ACTIVE);
        end
        else
        begin
            next_state.div_cnt = state.div_cnt + 16'h0001;
        end

        if (state.lf_cnt >= 16'(MPCM_LF_HALF - 1))
        begin
            next_state.lf_cnt   = 16'h0000;
            next_state.lf_level = ~state.lf_level;
        end
        else
        begin
            next_state.lf_cnt = state.lf_cnt + 16'h0001;
        end

        // read path
        next_state.rdata = 32'h0000_0000;
        if (bus_req && !wb_we_i)
        begin
            if (wb_adr_i == MPCM_ADDR_POWER_CONTROL)
            begin
                next_state.rdata[7:0] = state.power_control;
            end
            else if (wb_adr_i == MPCM_ADDR_CLOCK_CONTROL)
            begin
                next_state.rdata[7:0] = state.clock_control;
            end
            else if (wb_adr_i == MPCM_ADDR_POWER_DOWN)
            begin
                next_state.rdata[MPCM_PD_LFCLK_BIT] = state.lf_level;
            end
            else if (wb_adr_i == MPCM_ADDR_WAKEUP_CONFIG)
            begin
                next_state.rdata[7:0] = state.wakeup_configuration;
            end
            else if (wb_adr_i == MPCM_ADDR_RESET_CAUSE)
            begin
                next_state.rdata[0] = state.reset_cause;
            end
            else if (wb_adr_i == MPCM_ADDR_INT_ENABLE_HI)
            begin
                next_state.rdata[7:0] = state.interrupt_enable_high;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        // any reset source restarts the same sequence
        if (!reset_n || wdt_reset_req)
        begin
            state                       <= '0;
            state.power_control         <= MPCM_RST_POWER_CONTROL;
            state.clock_control         <= MPCM_RST_CLOCK_CONTROL;
            state.wakeup_configuration  <= MPCM_RST_WAKEUP_CONFIG;
            state.interrupt_enable_high <= MPCM_RST_INT_ENABLE_HI;
            state.mcu_state             <= MPCM_ST_ACTIVE;
            state.pll_on                <= 1'b1;
            state.div_limit             <= 16'h0001;
            // cause survives only its own reset path
            state.reset_cause           <= reset_n & wdt_reset_req;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign wb_dat_o          = state.rdata;
    assign wb_ack_o          = state.ack;
    assign pll_enable        = state.pll_on;
    assign mcu_clk_en        = state.clk_en;
    assign mcu_standby       = (state.mcu_state == MPCM_ST_STANDBY);
    assign low_freq_clock    = state.lf_level;
    assign baud_doubler      = state.power_control[MPCM_PC_SMOD_BIT];
    assign prog_write_enable = state.power_control[MPCM_PC_PMW_BIT];
    assign stop_request      = state.stop_p;
    assign idle_request      = state.idle_p;

endmodule

/* File: design/mpcm_pkg.sv */
package mpcm_pkg;

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [7:0] MPCM_ADDR_POWER_CONTROL  = 8'h87;
    localparam logic [7:0] MPCM_ADDR_CLOCK_CONTROL  = 8'hA3;
    localparam logic [7:0] MPCM_ADDR_POWER_DOWN     = 8'hA4;
    localparam logic [7:0] MPCM_ADDR_WAKEUP_CONFIG  = 8'hA5;
    localparam logic [7:0] MPCM_ADDR_RESET_CAUSE    = 8'hB1;
    localparam logic [7:0] MPCM_ADDR_INT_ENABLE_HI  = 8'hB8;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] MPCM_RST_POWER_CONTROL   = 8'h00;
    localparam logic [7:0] MPCM_RST_CLOCK_CONTROL   = 8'h80;
    localparam logic [7:0] MPCM_RST_WAKEUP_CONFIG   = 8'h00;
    localparam logic [7:0] MPCM_RST_INT_ENABLE_HI   = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int MPCM_CC_PLL_BIT      = 7;
    localparam int MPCM_CC_ON_HI        = 6;
    localparam int MPCM_CC_ON_LO        = 4;
    localparam int MPCM_CC_OFF_HI       = 1;
    localparam int MPCM_CC_OFF_LO       = 0;
    localparam int MPCM_PD_LFCLK_BIT    = 3;
    localparam int MPCM_PD_CMD_HI       = 2;
    localparam int MPCM_PC_SMOD_BIT     = 7;
    localparam int MPCM_PC_PMW_BIT      = 4;
    localparam int MPCM_PC_STOP_BIT     = 1;
    localparam int MPCM_PC_IDLE_BIT     = 0;
    localparam logic [7:0] MPCM_PC_RW_MASK = 8'hFC;
    localparam int MPCM_WC_RF_LO        = 6;
    localparam int MPCM_WC_PIN_LO       = 4;
    localparam int MPCM_WC_USB_LO       = 2;
    localparam int MPCM_WC_USB_BUS_LO   = 0;
    localparam int MPCM_IE_RF_BIT       = 1;
    localparam int MPCM_IE_USB_BUS_BIT  = 3;
    localparam int MPCM_IE_USB_BIT      = 4;
    localparam int MPCM_IE_PIN_BIT      = 5;

    // ************************************************************
    // codes
    // ************************************************************
    localparam logic [1:0] MPCM_WAKE_IF_ENABLED = 2'h0;
    localparam logic [1:0] MPCM_WAKE_RESERVED   = 2'h1;
    localparam logic [1:0] MPCM_WAKE_ALWAYS     = 2'h2;
    localparam logic [1:0] MPCM_WAKE_IGNORE     = 2'h3;
    localparam logic [2:0] MPCM_ON_MAX_CODE     = 3'h4;

    // ************************************************************
    // timing: 250 MHz system clock; mcu clock rates as divide counts
    // ************************************************************
    localparam int MPCM_SYS_CLK_KHZ = 250000;
    localparam int MPCM_LF_CLK_KHZ  = 32;
    // half period of the low-frequency clock in system cycles
    localparam int MPCM_LF_HALF     = MPCM_SYS_CLK_KHZ / (2 * MPCM_LF_CLK_KHZ);
    localparam int MPCM_DIV_W       = 16;

    typedef enum logic [1:0]
    {
        MPCM_ST_ACTIVE  = 2'b00,
        MPCM_ST_STANDBY = 2'b01
    } mpcm_mcu_state_t;

endpackage

/* File: dv/mpcm_wake_model.sv */
`timescale 1ns/1ps
// ********************************
// wake sources of the mcu side
// ********************************
module mpcm_wake_model
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] req,
    output logic            rf_interrupt,
    output logic            pin_timer_wake_event,
    output logic            usb_interrupt,
    output logic            usb_bus_wake
);
    logic [3:0] src;
    assign {rf_interrupt, pin_timer_wake_event} = src[3:2];
    assign {usb_interrupt, usb_bus_wake} = src[1:0];
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            src <= 4'h0;
        else
            src <= req;
    end
endmodule

/* File: dv/mpcm_power_clock_properties.sv */
`timescale 1ns/1ps
module mpcm_power_clock_chk
    import mpcm_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        wdt_reset_req,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        usb_suspended,
    input wire logic        pll_enable,
    input wire logic        mcu_clk_en,
    input wire logic        mcu_standby,
    input wire logic        low_freq_clock,
    input wire logic        stop_request,
    input wire logic        idle_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n || wdt_reset_req);
    logic wr;
    // a write being taken, lane 0 enabled
    assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    a_standby_enter: assert property (
        wr && wb_adr_i == MPCM_ADDR_POWER_DOWN && wb_dat_i[2:0] != 3'h0
        |-> ##[1:2] mcu_standby) else $error("standby not entered");
    a_standby_zero: assert property (
        wr && wb_adr_i == MPCM_ADDR_POWER_DOWN && wb_dat_i[2:0] == 3'h0
        && !mcu_standby |=> !mcu_standby) else $error("zero write slept");
    a_standby_noclk: assert property (
        mcu_standby && $past(mcu_standby) |-> !mcu_clk_en)
        else $error("mcu clock runs in standby");
    a_lf_half: assert property (
        $changed(low_freq_clock) |=> $stable(low_freq_clock) [*8])
        else $error("low clock toggles too fast");
    a_stop_cause: assert property (
        stop_request |-> $past(wb_we_i && wb_adr_i == MPCM_ADDR_POWER_CONTROL
        && wb_dat_i[1] && wb_sel_i[0])) else $error("stop without write");
    a_idle_cause: assert property (
        idle_request |-> !$past(idle_request) && $past(wb_we_i && wb_dat_i[0]
        && wb_adr_i == MPCM_ADDR_POWER_CONTROL)) else $error("idle bad");
    a_pll_forced: assert property (
        !usb_suspended [*2] |-> pll_enable) else $error("pll off in use");
    a_pll_off: assert property (
        wr && wb_adr_i == MPCM_ADDR_CLOCK_CONTROL && !wb_dat_i[7]
        && usb_suspended |-> ##[1:2] !pll_enable) else $error("pll stays on");
    a_clk_gap: assert property (
        mcu_clk_en |=> !mcu_clk_en [*8]) else $error("short mcu clock");
endmodule
bind mpcm_power_clock mpcm_power_clock_chk chk (.clk, .reset_n,
    .wdt_reset_req, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .usb_suspended, .pll_enable, .mcu_clk_en,
    .mcu_standby, .low_freq_clock, .stop_request, .idle_request);

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import mpcm_pkg::*;
    logic        clk, reset_n, wdt, cyc, stb, we, susp, ack, rf, pn, ui, uw;
    logic        pll, cen, sby, lf, bd, pwe, stp, idl;
    logic [7:0]  adr, r;
    logic [3:0]  sel, wk;
    logic [31:0] dat, rdat;
    logic [7:0]  q[$];
    int          mismatches, checked, n, ns, ni, es, ei;
    logic [7:0]  cc[9] = '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hC0, 8'h00, 8'h01,
                           8'h02, 8'h03};
    int          pp[9] = '{15, 20, 31, 62, 156, 62, 156, 781, 3906};
    mpcm_power_clock uut (.clk(clk), .reset_n(reset_n), .wdt_reset_req(wdt),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .usb_suspended(susp), .rf_interrupt(rf), .pin_timer_wake_event(pn),
        .usb_interrupt(ui), .usb_bus_wake(uw), .pll_enable(pll),
        .mcu_clk_en(cen), .mcu_standby(sby), .low_freq_clock(lf),
        .baud_doubler(bd), .prog_write_enable(pwe), .stop_request(stp),
        .idle_request(idl));
    mpcm_wake_model wm (.clk(clk), .reset_n(reset_n), .req(wk),
        .rf_interrupt(rf), .pin_timer_wake_event(pn), .usb_interrupt(ui),
        .usb_bus_wake(uw));
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // ********************************
    // bench tasks
    // ********************************
    task automatic check(string what, logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick(int k = 1);
        repeat (k) @(posedge clk);
    endtask
    task automatic wb(logic w, logic [7:0] a, logic [7:0] d,
                      logic [3:0] s = 4'hF);
        int t;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 24'h0, d, s};
        t = 0;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (ack !== 1'b1 && t < 100);
        if (t >= 100)
            mismatches++;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        q.push_back(e);
        wb(0, a, 8'h00);
    endtask
    // waits for the next mcu clock enable, or for lf at level v
    task automatic wait_for(logic en, logic v);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while ((en ? cen : lf) !== v && n < 9000);
        if (n >= 9000)
            mismatches++;
    endtask
    task automatic stby(logic [7:0] cfg, logic [7:0] ie, logic [3:0] s,
                        logic wake);
        wb(1, MPCM_ADDR_WAKEUP_CONFIG, cfg);
        wb(1, MPCM_ADDR_INT_ENABLE_HI, ie);
        wb(1, MPCM_ADDR_POWER_DOWN, 8'($urandom_range(7, 1)));
        tick(2);
        check("standby", sby, 1);
        wk <= s;
        tick(4);
        check("wake", sby, !wake);
        wk <= 4'h0;
        wb(1, MPCM_ADDR_WAKEUP_CONFIG, 8'hAA);
        wk <= 4'hF;
        tick(4);
        wk <= 4'h0;
        check("resume", sby, 0);
    endtask
    // read results are compared as the acks come back
    // stop and idle pulses are counted as they pass
    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0)
            check("rdata", rdat, {24'h0, q.pop_front()});
        ns += int'(stp === 1'b1);
        ni += int'(idl === 1'b1);
    end
    initial
    begin
        #200000;
        mismatches++;
        finish_test();
    end
    // ********************************
    // main sequence
    // ********************************
    initial
    begin
        {reset_n, wdt, cyc, stb, we, adr, dat, wk} = '0;
        {susp, sel} = 5'h1F;
        void'($urandom(81062));
        tick(4);
        reset_n <= 1;
        rd(MPCM_ADDR_CLOCK_CONTROL, 8'h80);
        rd(MPCM_ADDR_WAKEUP_CONFIG, 8'h00);
        rd(MPCM_ADDR_RESET_CAUSE, 8'h00);
        rd(MPCM_ADDR_POWER_CONTROL, 8'h00);
        rd(8'h10, 8'h00);
        wb(1, MPCM_ADDR_POWER_CONTROL, 8'hFF);
        repeat (4)
        begin
            r = 8'($urandom);
            wb(1, MPCM_ADDR_POWER_CONTROL, r);
            rd(MPCM_ADDR_POWER_CONTROL, r & MPCM_PC_RW_MASK);
            check("doubler", bd, r[7]);
            check("prog write", pwe, r[4]);
            es += r[1];
            ei += r[0];
        end
        wb(1, MPCM_ADDR_POWER_CONTROL, ~r, 4'hE);
        rd(MPCM_ADDR_POWER_CONTROL, r & MPCM_PC_RW_MASK);
        check("stop pulses", ns, es + 1);
        check("idle pulses", ni, ei + 1);
        wb(1, MPCM_ADDR_CLOCK_CONTROL, 8'hB3);
        wb(1, MPCM_ADDR_CLOCK_CONTROL, 8'hD3);
        rd(MPCM_ADDR_CLOCK_CONTROL, 8'hB3);
        wb(1, MPCM_ADDR_CLOCK_CONTROL, 8'h01);
        tick(3);
        check("pll off", pll, 0);
        susp <= 0;
        tick(3);
        check("pll forced", pll, 1);
        susp <= 1;
        for (int i = 0; i < 9; i++)
        begin
            wb(1, MPCM_ADDR_CLOCK_CONTROL, cc[i]);
            repeat (3)
                wait_for(1, 1);
            check("mcu period", n, pp[i]);
        end
        wait_for(0, 0);
        wait_for(0, 1);
        rd(MPCM_ADDR_POWER_DOWN, 8'h08);
        stby(8'h00, 8'h02, 4'h8, 1);
        stby(8'h00, 8'h00, 4'h8, 0);
        stby(8'h80, 8'h00, 4'h8, 1);
        stby(8'hC0, 8'h02, 4'h8, 0);
        stby(8'h20, 8'h00, 4'h4, 1);
        stby(8'h00, 8'h20, 4'h4, 1);
        stby(8'h08, 8'h00, 4'h2, 1);
        stby(8'h00, 8'h10, 4'h2, 1);
        stby(8'h02, 8'h00, 4'h1, 1);
        stby(8'h00, 8'h08, 4'h1, 1);
        stby(8'hFF, 8'hFF, 4'hF, 0);
        rd(MPCM_ADDR_INT_ENABLE_HI, 8'hFF);
        wb(1, MPCM_ADDR_WAKEUP_CONFIG, 8'h55);
        rd(MPCM_ADDR_WAKEUP_CONFIG, 8'hAA);
        wb(1, MPCM_ADDR_POWER_DOWN, 8'hF8);
        tick(2);
        check("no standby", sby, 0);
        wdt <= 1;
        tick();
        wdt <= 0;
        rd(MPCM_ADDR_RESET_CAUSE, 8'h01);
        rd(MPCM_ADDR_CLOCK_CONTROL, 8'h80);
        reset_n <= 0;
        tick(4);
        reset_n <= 1;
        rd(MPCM_ADDR_RESET_CAUSE, 8'h00);
        tick(2);
        finish_test();
    end
endmodule
